// ===== logic/lcgs_defs.svh
// register offsets, field positions and reset values of the gate input select stage
`ifndef LCGS_DEFS_SVH
`define LCGS_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define LCGS_OFS_GATE0      4'h0
`define LCGS_OFS_GATE1      4'h1
`define LCGS_OFS_GATE2      4'h2
`define LCGS_OFS_POLARITY   4'h3
`define LCGS_OFS_IN1_SRC    4'h4
`define LCGS_OFS_IN2_SRC    4'h5
`define LCGS_OFS_IN3_SRC    4'h6
`define LCGS_OFS_IN4_SRC    4'h7

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
// within a term pair the true select sits one above the inverted select
`define LCGS_TRUE_BIT       1
`define LCGS_INV_BIT        0
`define LCGS_NUM_GATES      3
`define LCGS_NUM_INPUTS     4
`define LCGS_SRC_W          6
`define LCGS_NUM_SRC        64

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LCGS_RDATA_RST      8'h00
`define LCGS_GATE_RST       3'h0
`define LCGS_DIN_RST        4'h0

`endif

// ===== logic/lcgs_pkg.sv
// types shared by the gate input select stage
`default_nettype none
`include "lcgs_defs.svh"

package lcgs_pkg;

    typedef logic [7:0]                   lcgs_byte_t;
    typedef logic [`LCGS_SRC_W-1:0]       lcgs_src_sel_t;
    typedef logic [`LCGS_NUM_SRC-1:0]     lcgs_src_bus_t;
    typedef logic [`LCGS_NUM_INPUTS-1:0]  lcgs_din_t;
    typedef logic [`LCGS_NUM_GATES-1:0]   lcgs_gates_t;

endpackage

`default_nettype wire

// ===== logic/lcgs_gate.sv
// one gate: OR of the selected true and inverted data terms, then polarity
`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defs.svh"

module lcgs_gate
    import lcgs_pkg::*;
(
    input  wire lcgs_byte_t  sel,
    input  wire lcgs_din_t   din,
    input  wire logic        invert,
    output logic             gate_out
);

    lcgs_din_t true_term;
    lcgs_din_t inv_term;

    // ------------------------------------------------------------------------
    // term selection, pair k holds input k+1
    // ------------------------------------------------------------------------
    for (genvar k = 0; k < `LCGS_NUM_INPUTS; k++)
    begin : g_term
        assign true_term[k] = sel[2*k+`LCGS_TRUE_BIT] & din[k];
        assign inv_term[k]  = sel[2*k+`LCGS_INV_BIT] & ~din[k];
    end

    // empty selection gives zero before polarity
    assign gate_out = ((|true_term) | (|inv_term)) ^ invert;

endmodule // lcgs_gate

`default_nettype wire

// ===== logic/lcgs_top.sv
// register bank, input source muxes and three term-select gates of a logic cell
//
// Operation
// - gate 0 select: four true/inverted pairs
// - gate 1 select: same pair layout
// - gate 2 select: same pair layout
// - true bit set routes input uninverted
// - inverted bit set routes input complement
// - selects read/write, unaffected by ordinary reset
// - each data input picked by 6-bit source
// - polarity bit inverts gate output
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defs.svh"

module lcgs_top
    import lcgs_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [3:0]     addr,
    input  wire lcgs_byte_t     wr_data,
    input  wire logic           wr_en,
    input  wire logic           rd_en,
    output lcgs_byte_t          rd_data,
    input  wire lcgs_src_bus_t  src_bus,
    output lcgs_din_t           cell_data_in,
    output lcgs_gates_t         gate_out
);

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    // no reset on purpose: contents survive every reset but power-up
    lcgs_byte_t     gate_sel_q [`LCGS_NUM_GATES];
    lcgs_gates_t    gate_pol_q;
    lcgs_src_sel_t  src_sel_q  [`LCGS_NUM_INPUTS];

    lcgs_byte_t     rd_data_d;
    lcgs_byte_t     rd_data_q;
    lcgs_din_t      din;
    lcgs_din_t      din_q;
    lcgs_gates_t    gate_d;
    lcgs_gates_t    gate_q;

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            case (addr)
                `LCGS_OFS_GATE0:    gate_sel_q[0] <= wr_data;
                `LCGS_OFS_GATE1:    gate_sel_q[1] <= wr_data;
                `LCGS_OFS_GATE2:    gate_sel_q[2] <= wr_data;
                `LCGS_OFS_POLARITY: gate_pol_q    <= wr_data[`LCGS_NUM_GATES-1:0];
                `LCGS_OFS_IN1_SRC:  src_sel_q[0]  <= wr_data[`LCGS_SRC_W-1:0];
                `LCGS_OFS_IN2_SRC:  src_sel_q[1]  <= wr_data[`LCGS_SRC_W-1:0];
                `LCGS_OFS_IN3_SRC:  src_sel_q[2]  <= wr_data[`LCGS_SRC_W-1:0];
                `LCGS_OFS_IN4_SRC:  src_sel_q[3]  <= wr_data[`LCGS_SRC_W-1:0];
                default:            ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    always_comb
    begin
        rd_data_d = `LCGS_RDATA_RST;
        if (rd_en)
        begin
            case (addr)
                `LCGS_OFS_GATE0:    rd_data_d = gate_sel_q[0];
                `LCGS_OFS_GATE1:    rd_data_d = gate_sel_q[1];
                `LCGS_OFS_GATE2:    rd_data_d = gate_sel_q[2];
                `LCGS_OFS_POLARITY: rd_data_d = {5'h0, gate_pol_q};
                `LCGS_OFS_IN1_SRC:  rd_data_d = {2'h0, src_sel_q[0]};
                `LCGS_OFS_IN2_SRC:  rd_data_d = {2'h0, src_sel_q[1]};
                `LCGS_OFS_IN3_SRC:  rd_data_d = {2'h0, src_sel_q[2]};
                `LCGS_OFS_IN4_SRC:  rd_data_d = {2'h0, src_sel_q[3]};
                default:            rd_data_d = `LCGS_RDATA_RST;
            endcase
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rd_data_q <= `LCGS_RDATA_RST;
        else
            rd_data_q <= rd_data_d;
    end

    assign rd_data = rd_data_q;

    // ------------------------------------------------------------------------
    // data input source muxes
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < `LCGS_NUM_INPUTS; i++)
    begin : g_src
        assign din[i] = src_bus[src_sel_q[i]];
    end

    // ------------------------------------------------------------------------
    // gates
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < `LCGS_NUM_GATES; g++)
    begin : g_gate
        lcgs_gate i_lcgs_gate (
            .sel      (gate_sel_q[g]),
            .din      (din),
            .invert   (gate_pol_q[g]),
            .gate_out (gate_d[g])
        );
    end

    // registered so every output leaves straight from a flop; costs one cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            din_q  <= `LCGS_DIN_RST;
            gate_q <= `LCGS_GATE_RST;
        end
        else
        begin
            din_q  <= din;
            gate_q <= gate_d;
        end
    end

    assign cell_data_in = din_q;
    assign gate_out     = gate_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    chk_gate0_store: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr == `LCGS_OFS_GATE0) |=> gate_sel_q[0] == $past(wr_data))
        else $error("gate 0 select did not take write data");

    chk_gate1_store: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr == `LCGS_OFS_GATE1) |=> gate_sel_q[1] == $past(wr_data))
        else $error("gate 1 select did not take write data");

    chk_gate2_store: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr == `LCGS_OFS_GATE2) |=> gate_sel_q[2] == $past(wr_data))
        else $error("gate 2 select did not take write data");

    chk_true_term_route: assert property (
        @(posedge clk) disable iff (!rst_n)
        (gate_sel_q[0] == 8'h80 && !gate_pol_q[0]) |=> gate_out[0] == $past(din[3]))
        else $error("true term of input 4 not routed into gate 0");

    chk_inv_term_route: assert property (
        @(posedge clk) disable iff (!rst_n)
        (gate_sel_q[1] == 8'h01 && !gate_pol_q[1]) |=> gate_out[1] == !$past(din[0]))
        else $error("inverted term of input 1 not routed into gate 1");

    chk_gate_readback: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr == `LCGS_OFS_GATE2) ##1 (rd_en && addr == `LCGS_OFS_GATE2 && !wr_en)
        |=> rd_data == $past(wr_data, 2))
        else $error("gate 2 select read back wrong value");

    chk_src_mux: assert property (
        @(posedge clk) disable iff (!rst_n)
        src_sel_q[2] == $past(src_sel_q[2]) |=> cell_data_in[2] == $past(src_bus[src_sel_q[2]]))
        else $error("data input 3 not taken from selected source");

    chk_pol_invert: assert property (
        @(posedge clk) disable iff (!rst_n)
        (gate_pol_q[2] && gate_sel_q[2] == 8'h20) |=> gate_out[2] == !$past(din[2]))
        else $error("gate 2 polarity did not invert output");

    chk_empty_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        (gate_sel_q[0] == 8'h00 && !gate_pol_q[0]) [*2] |-> gate_out[0] == 1'b0)
        else $error("gate 0 with no terms is not zero");

    chk_read_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd_en |=> rd_data == `LCGS_RDATA_RST)
        else $error("read data stands longer than one cycle");

    chk_pol_store: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr == `LCGS_OFS_POLARITY) |=> gate_pol_q == $past(wr_data[2:0]))
        else $error("polarity register did not take write data");

    chk_src_store: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr == `LCGS_OFS_IN1_SRC) |=> src_sel_q[0] == $past(wr_data[5:0]))
        else $error("source select of input 1 did not take write data");

    chk_both_terms: assert property (
        @(posedge clk) disable iff (!rst_n)
        (gate_sel_q[2] == 8'h0c && !gate_pol_q[2]) |=> gate_out[2] == 1'b1)
        else $error("true and inverted terms together do not give one");

    chk_all_true: assert property (
        @(posedge clk) disable iff (!rst_n)
        (gate_sel_q[2] == 8'haa && !gate_pol_q[2]) |=> gate_out[2] == $past(|din))
        else $error("gate 2 with all true terms is not the or of inputs");

    chk_unmapped_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_en && addr > `LCGS_OFS_IN4_SRC) |=> rd_data == `LCGS_RDATA_RST)
        else $error("unmapped read returned nonzero data");

    chk_unmapped_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_en && addr > `LCGS_OFS_IN4_SRC)
        |=> $stable(gate_sel_q[0]) && $stable(gate_sel_q[1]) && $stable(gate_sel_q[2]))
        else $error("unmapped write disturbed a gate select");

    // no disable here: this one watches the reset itself
    chk_outputs_reset: assert property (
        @(posedge clk)
        !rst_n |=> gate_out == `LCGS_GATE_RST && cell_data_in == `LCGS_DIN_RST
                   && rd_data == `LCGS_RDATA_RST)
        else $error("outputs not cleared by reset");

endmodule // lcgs_top

`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the gate input select stage
`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defs.svh"

module tb_top
    import lcgs_pkg::*;
;
    typedef struct packed {
        lcgs_byte_t  g0;
        lcgs_byte_t  g1;
        lcgs_byte_t  g2;
        logic [2:0]  pol;
        lcgs_din_t   din;
        lcgs_gates_t exp;
    } lcgs_row_t;

    logic          clk          = 1'b0;
    logic          rst_n        = 1'b0;
    logic [3:0]    addr         = 4'h0;
    lcgs_byte_t    wr_data      = 8'h00;
    logic          wr_en        = 1'b0;
    logic          rd_en        = 1'b0;
    lcgs_src_bus_t src_bus      = 64'hffff_ffff_ffff_ffff;
    lcgs_byte_t    rd_data;
    lcgs_din_t     cell_data_in;
    lcgs_gates_t   gate_out;
    int            bad_count    = 0;
    int            num_checks   = 0;
    // sources far apart so a wrong pick lands on a decoy
    int            src_idx [4]  = '{5, 17, 40, 63};
    lcgs_row_t     rows [8]     = '{
        '{8'h02, 8'h01, 8'h00, 3'h0, 4'h1, 3'h1},
        '{8'h02, 8'h01, 8'h00, 3'h0, 4'h0, 3'h2},
        '{8'h80, 8'h40, 8'h00, 3'h4, 4'h8, 3'h5},
        '{8'h20, 8'h08, 8'h0c, 3'h3, 4'h4, 3'h6},
        '{8'hff, 8'h55, 8'haa, 3'h0, 4'hf, 3'h5},
        '{8'h00, 8'h30, 8'h20, 3'h4, 4'h4, 3'h2},
        '{8'h00, 8'h00, 8'h20, 3'h6, 4'h0, 3'h6},
        '{8'h10, 8'h04, 8'h00, 3'h7, 4'h0, 3'h4}};

    always #12.5 clk = ~clk;

    lcgs_top i_lcgs_top (
        .clk          (clk),
        .rst_n        (rst_n),
        .addr         (addr),
        .wr_data      (wr_data),
        .wr_en        (wr_en),
        .rd_en        (rd_en),
        .rd_data      (rd_data),
        .src_bus      (src_bus),
        .cell_data_in (cell_data_in),
        .gate_out     (gate_out)
    );

    // ------------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] got);
        num_checks++;
        if (got !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input lcgs_byte_t d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input lcgs_byte_t e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_data", e, rd_data);
        @(posedge clk);
        #1;
        chk("rd_data idle", 8'h00, rd_data);
    endtask

    // decoys held at 1, chosen sources carry the wanted data
    function automatic lcgs_src_bus_t make_bus(input lcgs_din_t d);
        lcgs_src_bus_t b;
        b = 64'hffff_ffff_ffff_ffff;
        for (int k = 0; k < 4; k++)
            b[src_idx[k]] = d[k];
        return b;
    endfunction

    task automatic end_of_test;
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 4; k++)
            wr(4'(`LCGS_OFS_IN1_SRC + k), 8'(src_idx[k]));
        foreach (rows[i])
        begin
            wr(`LCGS_OFS_GATE0, rows[i].g0);
            wr(`LCGS_OFS_GATE1, rows[i].g1);
            wr(`LCGS_OFS_GATE2, rows[i].g2);
            wr(`LCGS_OFS_POLARITY, {5'h00, rows[i].pol});
            @(posedge clk);
            src_bus <= make_bus(rows[i].din);
            repeat (2) @(posedge clk);
            #1;
            chk("cell_data_in", rows[i].din, cell_data_in);
            chk("gate_out", rows[i].exp, gate_out);
        end
        // write then read back in the very next cycle
        @(posedge clk);
        addr    <= `LCGS_OFS_GATE2;
        wr_data <= 8'h5a;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        @(posedge clk);
        rd_en   <= 1'b0;
        #1;
        chk("rd_data after write", 8'h5a, rd_data);
        rd(`LCGS_OFS_GATE0, 8'h10);
        rd(`LCGS_OFS_GATE1, 8'h04);
        rd(`LCGS_OFS_GATE2, 8'h5a);
        rd(`LCGS_OFS_IN4_SRC, 8'h3f);
        wr(4'h9, 8'ha5);
        rd(4'h9, 8'h00);
        // an ordinary reset must leave every gate select intact
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("gate_out in reset", 3'h0, gate_out);
        @(posedge clk);
        rst_n <= 1'b1;
        rd(`LCGS_OFS_GATE0, 8'h10);
        rd(`LCGS_OFS_GATE1, 8'h04);
        rd(`LCGS_OFS_GATE2, 8'h5a);
        end_of_test();
    end

    // whole run is about 135 cycles; 3000 leaves a wide margin
    initial
    begin
        #75000;
        bad_count++;
        end_of_test();
    end

endmodule // tb_top
`default_nettype wire
